//--- src/ulm_uart.sv
// Purpose: serial port with line status flags, modem control and loopback
// Assumes: inputs synchronous to mclk, APB slave with no wait states
// Notes: fixed 8 data bits and one stop bit, baud fixed by package constant
//
// How it works
// - fifo error flag zero unless fifo mode
// - status read clears fifo error if none left
// - all-empty means shift and holding both empty
// - holding-empty set when holding/fifo drains
// - data write clears holding-empty flag
// - holding-empty plus enable raises interrupt
// - break after full character of spacing
// - framing error on missing stop bit
// - parity error on mismatched parity bit
// - fifo mode error flags follow head byte
// - status read clears error and overrun flags
// - overrun when a character arrives with no room; only non-fifo mode overwrites the unread one
// - data ready while any byte waits
// - loopback holds serial out high, isolates input
// - loopback forces modem outputs inactive
// - loopback feeds control bits to modem inputs
// - interrupt pin driven only when enabled
// - loopback ring bit ignored outside loopback
// - send-request pin is inverted control bit
// - terminal-ready pin is inverted control bit
// - fifo enable bit selects fifo mode
// - modem status inverts pins or copies loopback bits
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

module ulm_uart (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic serial_in,
   output logic serial_out,
   // modem lines
   output logic term_ready_out_n,
   output logic send_req_out_n,
   input wire logic clear_to_send_in_n,
   input wire logic set_ready_in_n,
   input wire logic ring_in_n,
   input wire logic carrier_detect_in_n,
   // interrupt pin
   output logic irq_out,
   output logic irq_oe_n
);

   typedef enum logic [2:0] {
      ULM_TX_IDLE = 3'b000,
      ULM_TX_START = 3'b001,
      ULM_TX_DATA = 3'b010,
      ULM_TX_PAR = 3'b011,
      ULM_TX_STOP = 3'b100
   } ulm_tx_state_t;

   typedef enum logic [2:0] {
      ULM_RX_IDLE = 3'b000,
      ULM_RX_START = 3'b001,
      ULM_RX_DATA = 3'b010,
      ULM_RX_PAR = 3'b011,
      ULM_RX_STOP = 3'b100,
      ULM_RX_WAIT = 3'b101
   } ulm_rx_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   localparam int RX_W = ulm_pkg::RX_ENTRY_W;
   localparam int FIFO_D = ulm_pkg::FIFO_DEPTH;
   logic [7:0] int_en_q;
   logic [7:0] line_ctrl_q;
   logic [7:0] modem_ctrl_q;
   logic fifo_en_q;
   logic [31:0] prdata_q;
   logic oe_q, pe_q, fe_q, bi_q, fifo_err_q;
   logic irq_q;
   logic [RX_W-1:0] rx_mem [FIFO_D];
   logic [7:0] tx_mem [FIFO_D];
   logic [3:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q;
   logic [4:0] rx_cnt_q, tx_cnt_q, err_cnt_q;
   ulm_tx_state_t tx_state_q;
   ulm_rx_state_t rx_state_q;
   logic [7:0] tx_tick_q, rx_tick_q;
   logic [2:0] tx_bit_q, rx_bit_q;
   logic [7:0] tx_shift_q, rx_shift_q;
   logic tx_par_q, rx_par_q, tx_line_q;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire loop = modem_ctrl_q[ulm_pkg::MC_LOOPBACK];
   wire fifo_mode = fifo_en_q;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire access = psel & penable;
   wire bus_wr = access & pwrite;
   wire bus_rd = access & ~pwrite;
   wire hit_data = paddr == ulm_pkg::OFF_DATA;
   wire hit_ie = paddr == ulm_pkg::OFF_INT_EN;
   wire hit_fc = paddr == ulm_pkg::OFF_FIFO_CTRL;
   wire hit_lc = paddr == ulm_pkg::OFF_LINE_CTRL;
   wire hit_mc = paddr == ulm_pkg::OFF_MODEM_CTRL;
   wire hit_ls = paddr == ulm_pkg::OFF_LINE_STATUS;
   wire hit_ms = paddr == ulm_pkg::OFF_MODEM_STATUS;
   wire mapped = hit_data | hit_ie | hit_fc | hit_lc | hit_mc | hit_ls | hit_ms;
   wire fc_wr = bus_wr & hit_fc;
   wire mode_chg = fc_wr & (pwdata[ulm_pkg::FC_FIFO_EN] != fifo_en_q);
   wire rx_clr = (fc_wr & pwdata[ulm_pkg::FC_RX_RST]) | mode_chg;
   wire tx_clr = (fc_wr & pwdata[ulm_pkg::FC_TX_RST]) | mode_chg;
   wire ls_rd = bus_rd & hit_ls;
   wire [7:0] ls_seen = ls_rd ? prdata_q[7:0] : 8'h00;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // modem lines and loopback
   wire par_en = line_ctrl_q[ulm_pkg::LC_PARITY_EN];
   wire par_even = line_ctrl_q[ulm_pkg::LC_EVEN];
   wire rx_line = loop ? tx_line_q : serial_in;
   assign serial_out = loop | tx_line_q;
   assign term_ready_out_n = loop | ~modem_ctrl_q[ulm_pkg::MC_TERM_READY];
   assign send_req_out_n = loop | ~modem_ctrl_q[ulm_pkg::MC_SEND_REQ];
   wire ms_cts = loop ? modem_ctrl_q[ulm_pkg::MC_SEND_REQ] : ~clear_to_send_in_n;
   wire ms_dsr = loop ? modem_ctrl_q[ulm_pkg::MC_TERM_READY] : ~set_ready_in_n;
   wire ms_ring = loop ? modem_ctrl_q[ulm_pkg::MC_LOOP_RING] : ~ring_in_n;
   wire ms_dcd = loop ? modem_ctrl_q[ulm_pkg::MC_IRQ_EN] : ~carrier_detect_in_n;
   wire [7:0] modem_status = {ms_dcd, ms_ring, ms_dsr, ms_cts, 4'h0};

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer
   wire [4:0] cap = fifo_mode ? ulm_pkg::FIFO_CAP : ulm_pkg::SINGLE_CAP;
   wire rx_tick = rx_tick_q == 8'h00;
   wire rx_push = (rx_state_q == ULM_RX_STOP) & rx_tick;
   wire exp_par = par_even ? ^rx_shift_q : ~^rx_shift_q;
   wire got_fe = ~rx_line;
   wire got_pe = par_en & (rx_par_q != exp_par);
   // line low through start, data, parity and stop
   wire got_bi = ~rx_line & (rx_shift_q == 8'h00) & (~par_en | ~rx_par_q);
   wire [RX_W-1:0] rx_entry = {got_bi, got_fe, got_pe, rx_shift_q};
   wire entry_err = got_bi | got_fe | got_pe;
   wire rx_pop = bus_rd & hit_data & (rx_cnt_q != 5'h00);
   wire rx_room = (rx_cnt_q != cap) | rx_pop;
   wire rx_store = rx_push & rx_room;
   wire rx_overrun = rx_push & ~rx_room;
   wire rx_overwrite = rx_overrun & ~fifo_mode;
   wire [RX_W-1:0] rx_head = rx_mem[rx_rd_q];
   wire [RX_W-1:0] rx_second = rx_mem[rx_rd_q + 4'h1];
   wire head_err = rx_head[ulm_pkg::RE_BI] | rx_head[ulm_pkg::RE_FE] | rx_head[ulm_pkg::RE_PE];
   // a new byte becomes head of the buffer
   wire new_from_entry = rx_overwrite | (rx_store & (rx_cnt_q == 5'h00))
      | (rx_store & rx_pop & (rx_cnt_q == 5'h01));
   wire new_from_second = rx_pop & (rx_cnt_q > 5'h01);
   wire [2:0] head_flags = new_from_entry ? rx_entry[RX_W-1:8] :
      (new_from_second ? rx_second[RX_W-1:8] : 3'b000);
   wire [4:0] err_inc = {4'h0, rx_store & entry_err};
   wire [4:0] err_dec = {4'h0, rx_pop & head_err};
   wire [4:0] err_cnt_d = rx_clr ? 5'h00 : err_cnt_q + err_inc - err_dec;
   wire [4:0] rx_cnt_d = rx_cnt_q + {4'h0, rx_store} - {4'h0, rx_pop};

   // set wins over a read clear; only bits already returned are cleared
   wire oe_d = (oe_q & ~ls_seen[ulm_pkg::LS_OVERRUN]) | rx_overrun;
   wire pe_d = (pe_q & ~ls_seen[ulm_pkg::LS_PARITY]) | head_flags[0];
   wire fe_d = (fe_q & ~ls_seen[ulm_pkg::LS_FRAMING]) | head_flags[1];
   wire bi_d = (bi_q & ~ls_seen[ulm_pkg::LS_BREAK]) | head_flags[2];
   wire fifo_err_clr = ls_seen[ulm_pkg::LS_FIFO_ERR] & (err_cnt_d == 5'h00);
   wire fifo_err_d = fifo_mode & ~mode_chg
      & ((fifo_err_q & ~fifo_err_clr) | (rx_store & entry_err));

   ////////////////////////////////////////////////////////////////////////////
   // transmit buffer and status
   wire tx_push = bus_wr & hit_data & (tx_cnt_q != cap);
   wire tx_pop = (tx_state_q == ULM_TX_IDLE) & (tx_cnt_q != 5'h00);
   wire tx_tick = tx_tick_q == 8'h00;
   wire [7:0] tx_head = tx_mem[tx_rd_q];
   wire hold_empty = tx_cnt_q == 5'h00;
   wire all_empty = hold_empty & (tx_state_q == ULM_TX_IDLE);
   wire rx_ready = rx_cnt_q != 5'h00;
   wire [7:0] line_status = {fifo_err_q, all_empty, hold_empty, bi_q, fe_q, pe_q, oe_q,
      rx_ready};
   wire irq_d = modem_ctrl_q[ulm_pkg::MC_IRQ_EN]
      & ((int_en_q[ulm_pkg::IE_TX_EMPTY] & hold_empty)
      | (int_en_q[ulm_pkg::IE_RX_READY] & rx_ready));
   assign irq_out = irq_q;
   assign irq_oe_n = ~modem_ctrl_q[ulm_pkg::MC_IRQ_EN];

   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      if (hit_data)
         rd_mux = rx_head[7:0];
      else if (hit_ie)
         rd_mux = int_en_q;
      else if (hit_fc)
         rd_mux = {7'h00, fifo_en_q};
      else if (hit_lc)
         rd_mux = line_ctrl_q;
      else if (hit_mc)
         rd_mux = modem_ctrl_q;
      else if (hit_ls)
         rd_mux = line_status;
      else if (hit_ms)
         rd_mux = modem_status;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers and flags
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         int_en_q <= ulm_pkg::INT_EN_RST;
         line_ctrl_q <= ulm_pkg::LINE_CTRL_RST;
         modem_ctrl_q <= ulm_pkg::MODEM_CTRL_RST;
         fifo_en_q <= 1'b0;
         prdata_q <= ulm_pkg::PRDATA_RST;
         irq_q <= 1'b0;
      end
      else
      begin
         if (bus_wr & hit_ie)
            int_en_q <= pwdata[7:0];
         if (bus_wr & hit_lc)
            line_ctrl_q <= pwdata[7:0];
         if (bus_wr & hit_mc)
            modem_ctrl_q <= pwdata[7:0] & ulm_pkg::MC_MASK;
         if (fc_wr)
            fifo_en_q <= pwdata[ulm_pkg::FC_FIFO_EN];
         if (setup_rd)
            prdata_q <= {24'h00_0000, rd_mux};
         irq_q <= irq_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         oe_q <= 1'b0;
         pe_q <= 1'b0;
         fe_q <= 1'b0;
         bi_q <= 1'b0;
         fifo_err_q <= 1'b0;
         err_cnt_q <= 5'h00;
      end
      else
      begin
         oe_q <= oe_d;
         pe_q <= pe_d;
         fe_q <= fe_d;
         bi_q <= bi_d;
         fifo_err_q <= fifo_err_d;
         err_cnt_q <= err_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // buffer storage and pointers
   always_ff @(posedge mclk)
   begin
      if (rx_store)
         rx_mem[rx_wr_q] <= rx_entry;
      if (rx_overwrite)
         rx_mem[rx_rd_q] <= rx_entry;
      if (tx_push)
         tx_mem[tx_wr_q] <= pwdata[7:0];
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_wr_q <= 4'h0;
         rx_rd_q <= 4'h0;
         rx_cnt_q <= 5'h00;
         tx_wr_q <= 4'h0;
         tx_rd_q <= 4'h0;
         tx_cnt_q <= 5'h00;
      end
      else
      begin
         if (rx_clr)
         begin
            rx_wr_q <= 4'h0;
            rx_rd_q <= 4'h0;
            rx_cnt_q <= 5'h00;
         end
         else
         begin
            rx_wr_q <= rx_wr_q + {3'h0, rx_store};
            rx_rd_q <= rx_rd_q + {3'h0, rx_pop};
            rx_cnt_q <= rx_cnt_d;
         end
         if (tx_clr)
         begin
            tx_wr_q <= 4'h0;
            tx_rd_q <= 4'h0;
            tx_cnt_q <= 5'h00;
         end
         else
         begin
            tx_wr_q <= tx_wr_q + {3'h0, tx_push};
            tx_rd_q <= tx_rd_q + {3'h0, tx_pop};
            tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_state_q <= ULM_TX_IDLE;
         tx_tick_q <= 8'h00;
         tx_bit_q <= 3'h0;
         tx_shift_q <= 8'h00;
         tx_par_q <= 1'b0;
         tx_line_q <= 1'b1;
      end
      else
      begin
         tx_tick_q <= tx_tick ? ulm_pkg::BIT_LAST : tx_tick_q - 8'h01;
         unique case (tx_state_q)
            ULM_TX_IDLE:
            begin
               tx_tick_q <= ulm_pkg::BIT_LAST;
               if (tx_pop)
               begin
                  tx_shift_q <= tx_head;
                  tx_par_q <= par_even ? ^tx_head : ~^tx_head;
                  tx_line_q <= 1'b0;
                  tx_state_q <= ULM_TX_START;
               end
            end
            ULM_TX_START:
               if (tx_tick)
               begin
                  tx_line_q <= tx_shift_q[0];
                  tx_bit_q <= 3'h0;
                  tx_state_q <= ULM_TX_DATA;
               end
            ULM_TX_DATA:
               if (tx_tick)
               begin
                  tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q != 3'h7)
                     tx_line_q <= tx_shift_q[1];
                  else if (par_en)
                  begin
                     tx_line_q <= tx_par_q;
                     tx_state_q <= ULM_TX_PAR;
                  end
                  else
                  begin
                     tx_line_q <= 1'b1;
                     tx_state_q <= ULM_TX_STOP;
                  end
               end
            ULM_TX_PAR:
               if (tx_tick)
               begin
                  tx_line_q <= 1'b1;
                  tx_state_q <= ULM_TX_STOP;
               end
            ULM_TX_STOP:
               if (tx_tick)
                  tx_state_q <= ULM_TX_IDLE;
            default:
               tx_state_q <= ULM_TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_state_q <= ULM_RX_IDLE;
         rx_tick_q <= 8'h00;
         rx_bit_q <= 3'h0;
         rx_shift_q <= 8'h00;
         rx_par_q <= 1'b0;
      end
      else
      begin
         rx_tick_q <= rx_tick ? ulm_pkg::BIT_LAST : rx_tick_q - 8'h01;
         unique case (rx_state_q)
            ULM_RX_IDLE:
            begin
               rx_tick_q <= ulm_pkg::HALF_LAST;
               if (~rx_line)
                  rx_state_q <= ULM_RX_START;
            end
            ULM_RX_START:
               if (rx_tick)
               begin
                  rx_bit_q <= 3'h0;
                  rx_state_q <= rx_line ? ULM_RX_IDLE : ULM_RX_DATA;
               end
            ULM_RX_DATA:
               if (rx_tick)
               begin
                  rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == 3'h7)
                     rx_state_q <= par_en ? ULM_RX_PAR : ULM_RX_STOP;
               end
            ULM_RX_PAR:
               if (rx_tick)
               begin
                  rx_par_q <= rx_line;
                  rx_state_q <= ULM_RX_STOP;
               end
            ULM_RX_STOP:
               if (rx_tick)
                  rx_state_q <= rx_line ? ULM_RX_IDLE : ULM_RX_WAIT;
            ULM_RX_WAIT:
               if (rx_line)
                  rx_state_q <= ULM_RX_IDLE;
            default:
               rx_state_q <= ULM_RX_IDLE;
         endcase
      end
   end

endmodule

//--- src/ulm_pkg.sv
// Purpose: shared constants for the serial port status and modem control block
// Assumes: 10 MHz mclk, APB register access, fixed 8 data bits
// Notes: register offsets are byte addresses of aligned 32-bit words
package ulm_pkg;
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int BAUD_RATE = 115_200;
   localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
   localparam int HALF_CYC = BIT_CYC / 2;
   localparam int CYC_W = 8;
   localparam logic [CYC_W-1:0] BIT_LAST = CYC_W'(BIT_CYC - 1);
   localparam logic [CYC_W-1:0] HALF_LAST = CYC_W'(HALF_CYC - 1);

   // buffers
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FIFO_CAP = 5'h10;
   localparam logic [CNT_W-1:0] SINGLE_CAP = 5'h01;
   localparam int RX_ENTRY_W = 11;
   localparam int RE_PE = 8;
   localparam int RE_FE = 9;
   localparam int RE_BI = 10;

   // register offsets
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_DATA = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_INT_EN = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_FIFO_CTRL = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_LINE_CTRL = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_MODEM_CTRL = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_LINE_STATUS = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_MODEM_STATUS = 12'h018;

   // line status fields
   localparam int LS_RX_READY = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_PARITY = 2;
   localparam int LS_FRAMING = 3;
   localparam int LS_BREAK = 4;
   localparam int LS_HOLD_EMPTY = 5;
   localparam int LS_ALL_EMPTY = 6;
   localparam int LS_FIFO_ERR = 7;

   // modem control fields
   localparam int MC_TERM_READY = 0;
   localparam int MC_SEND_REQ = 1;
   localparam int MC_LOOP_RING = 2;
   localparam int MC_IRQ_EN = 3;
   localparam int MC_LOOPBACK = 4;
   localparam logic [7:0] MC_MASK = 8'h1F;

   // modem status fields
   localparam int MS_CLEAR_TO_SEND = 4;
   localparam int MS_SET_READY = 5;
   localparam int MS_RING = 6;
   localparam int MS_CARRIER = 7;

   // other control fields
   localparam int FC_FIFO_EN = 0;
   localparam int FC_RX_RST = 1;
   localparam int FC_TX_RST = 2;
   localparam int IE_RX_READY = 0;
   localparam int IE_TX_EMPTY = 1;
   localparam int LC_PARITY_EN = 3;
   localparam int LC_EVEN = 4;

   // reset values
   localparam logic [7:0] INT_EN_RST = 8'h00;
   localparam logic [7:0] LINE_CTRL_RST = 8'h00;
   localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
   localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
endpackage

//--- dv/ulm_chk.sv
// Purpose: port checker for the status and modem control block
// Assumes: apb writes land at the access edge, one clock domain
// Notes: modem control is shadowed from the writes seen on the bus
`timescale 1ns/10ps
module ulm_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial and modem lines
   input wire logic serial_out,
   input wire logic term_ready_out_n,
   input wire logic send_req_out_n,
   input wire logic clear_to_send_in_n,
   input wire logic set_ready_in_n,
   input wire logic ring_in_n,
   input wire logic carrier_detect_in_n,
   input wire logic irq_out,
   input wire logic irq_oe_n
);
   logic [4:0] mc_q;
   logic acc;
   logic map_ok;
   logic ms_rd;
   assign acc = psel && penable && pready;
   assign map_ok = (paddr[1:0] == 2'h0) && (paddr <= ulm_pkg::OFF_MODEM_STATUS);
   assign ms_rd = acc && !pwrite && (paddr == ulm_pkg::OFF_MODEM_STATUS);
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         mc_q <= 5'h00;
      else if (acc && pwrite && paddr == ulm_pkg::OFF_MODEM_CTRL)
         mc_q <= pwdata[4:0];
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   term_pin_a: assert property ($stable(mc_q) |-> term_ready_out_n == (mc_q[4] | ~mc_q[0]))
      else $error("terminal ready pin wrong");
   send_pin_a: assert property ($stable(mc_q) |-> send_req_out_n == (mc_q[4] | ~mc_q[1]))
      else $error("send request pin wrong");
   irq_drive_a: assert property ($stable(mc_q) |-> irq_oe_n == ~mc_q[3])
      else $error("interrupt drive enable wrong");
   irq_quiet_a: assert property (irq_oe_n && $past(irq_oe_n) |-> !irq_out)
      else $error("interrupt active while not driven");
   loop_idle_a: assert property (mc_q[4] && $past(mc_q[4]) |-> serial_out)
      else $error("serial out low in loopback");
   bad_addr_a: assert property (acc |-> pslverr == !map_ok)
      else $error("slave error flag wrong");
   bad_read_a: assert property (acc && !pwrite && !map_ok |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   ms_loop_a: assert property (ms_rd && mc_q[4] && $stable(mc_q) |->
      prdata[7:0] == {mc_q[3], mc_q[2], mc_q[0], mc_q[1], 4'h0})
      else $error("loopback modem status wrong");
   ms_pins_a: assert property (ms_rd && !mc_q[4] && $stable(mc_q) |->
      prdata[7:4] == ~{carrier_detect_in_n, ring_in_n, set_ready_in_n, clear_to_send_in_n})
      else $error("modem status wrong");
   cover property (ms_rd && mc_q[4]);
   cover property (acc && pslverr);
   cover property (irq_out);
endmodule

bind ulm_uart ulm_chk u_chk (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .serial_out, .term_ready_out_n, .send_req_out_n,
   .clear_to_send_in_n, .set_ready_in_n, .ring_in_n, .carrier_detect_in_n, .irq_out, .irq_oe_n);

//--- dv/ulm_peer.sv
// Purpose: far-side serial sender and modem line driver
// Assumes: bit time of ulm_pkg::BIT_CYC clocks, even parity
// Notes: line returns to idle high after every frame
`timescale 1ns/10ps
module ulm_peer (
   // clock
   input wire logic mclk,
   // serial line toward the port
   output logic line_out,
   // modem lines, active low: carrier, ring, set ready, clear to send
   output logic [3:0] lines_n
);
   initial
   begin
      line_out = 1'b1;
      lines_n = 4'hF;
   end
   task automatic set_lines(input logic [3:0] v);
      @(posedge mclk);
      lines_n <= ~v;
   endtask
   // one frame, lsb first; flaws are injected only on request
   task automatic send(input logic [7:0] d, input logic pbad, input logic stop, input logic brk);
      logic [10:0] f;
      f = {stop, (^d) ^ pbad, d, 1'b0};
      if (brk)
         f = 11'h000;
      for (int i = 0; i < 11; i++)
      begin
         @(posedge mclk);
         line_out <= f[i];
         repeat (ulm_pkg::BIT_CYC - 1) @(posedge mclk);
      end
      @(posedge mclk);
      line_out <= 1'b1;
      repeat (ulm_pkg::BIT_CYC) @(posedge mclk);
   endtask
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench for the status and modem control block
// Assumes: zero-wait apb slave, 10 MHz clock
// Notes: random data from a bench lfsr, loopback and external frames
`timescale 1ns/10ps
module tb;
   logic mclk, sys_rst, psel, penable, pwrite, serial_in;
   logic pready, pslverr, serial_out, term_ready_out_n, send_req_out_n, irq_out, irq_oe_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rnd;
   logic [3:0] lines_n, lv;
   logic [7:0] d, d2;
   logic [4:0] mc;
   int n_errors, total_checks;
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;
   ulm_uart DUT (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .serial_in, .serial_out, .term_ready_out_n, .send_req_out_n,
      .clear_to_send_in_n(lines_n[0]), .set_ready_in_n(lines_n[1]), .ring_in_n(lines_n[2]),
      .carrier_detect_in_n(lines_n[3]), .irq_out, .irq_oe_n);
   ulm_peer peer (.mclk, .line_out(serial_in), .lines_n);
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] ms_exp(input logic [4:0] m, input logic [3:0] v);
      return m[4] ? {24'h0, m[3], m[2], m[0], m[1], 4'h0} : {24'h0, v, 4'h0};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // polls line status; the last value read stays in rd
   task automatic wait_ls(input logic [7:0] m);
      int k;
      k = 0;
      rd = 32'h0;
      while ((rd[7:0] & m) !== m && k < 3000)
      begin
         apb(1'b0, ulm_pkg::OFF_LINE_STATUS, 32'h0);
         k++;
      end
      // a poll that runs out counts as a mismatch
      if ((rd[7:0] & m) !== m)
      begin
         n_errors++;
         $display("unexpected at %0t: status %h, wanted %h", $time, rd[7:0], m);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge mclk);
      n_errors++;
      finish_test;
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      sys_rst = 1'b1;
      rnd = 32'hFA3D4388;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h60);
      rd_chk(ulm_pkg::OFF_MODEM_CTRL, 32'h0);
      rd_chk(12'h01C, 32'h0);
      apb(1'b1, ulm_pkg::OFF_INT_EN, 32'h2);
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         mc = (i < 2) ? {i[0], 4'hF} : rnd[4:0];
         lv = rnd[11:8];
         apb(1'b1, ulm_pkg::OFF_MODEM_CTRL, {27'h0, mc});
         peer.set_lines(lv);
         repeat (4) @(posedge mclk);
         chk({30'h0, term_ready_out_n, send_req_out_n}, {30'h0, mc[4] | ~mc[0], mc[4] | ~mc[1]});
         chk({31'h0, irq_out}, {31'h0, mc[3]});
         rd_chk(ulm_pkg::OFF_MODEM_STATUS, ms_exp(mc, lv));
      end
      // single buffer loopback echo, then overrun
      d = rnd[23:16];
      d2 = ~d;
      apb(1'b1, ulm_pkg::OFF_MODEM_CTRL, 32'h10);
      apb(1'b1, ulm_pkg::OFF_DATA, {24'h0, d});
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h20);
      wait_ls(8'h41);
      rd_chk(ulm_pkg::OFF_DATA, {24'h0, d});
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h60);
      apb(1'b1, ulm_pkg::OFF_DATA, {24'h0, d});
      wait_ls(8'h20);
      apb(1'b1, ulm_pkg::OFF_DATA, {24'h0, d2});
      wait_ls(8'h02);
      chk(rd & 32'hBF, 32'h23);
      repeat (100) @(posedge mclk);
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h61);
      rd_chk(ulm_pkg::OFF_DATA, {24'h0, d2});
      // external frames with parity, framing and break faults
      apb(1'b1, ulm_pkg::OFF_MODEM_CTRL, 32'h0);
      apb(1'b1, ulm_pkg::OFF_LINE_CTRL, 32'h18);
      for (int i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         // nonzero data keeps a framing fault from also looking like a break
         d = (i == 2) ? 8'h00 : (rnd[7:0] | 8'h01);
         peer.send(d, i == 0, i != 1, i == 2);
         rd_chk(ulm_pkg::OFF_LINE_STATUS, (i == 0) ? 32'h65 : (i == 1) ? 32'h69 : 32'h79);
         rd_chk(ulm_pkg::OFF_DATA, {24'h0, d});
      end
      // fifo mode: error flags follow the head byte
      apb(1'b1, ulm_pkg::OFF_FIFO_CTRL, 32'h1);
      d2 = rnd[15:8];
      peer.send(d, 1'b1, 1'b1, 1'b0);
      peer.send(d2, 1'b0, 1'b1, 1'b0);
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'hE5);
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'hE1);
      rd_chk(ulm_pkg::OFF_DATA, {24'h0, d});
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'hE1);
      rd_chk(ulm_pkg::OFF_DATA, {24'h0, d2});
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h60);
      // fifo loopback: two bytes held, none lost
      apb(1'b1, ulm_pkg::OFF_MODEM_CTRL, 32'h10);
      apb(1'b1, ulm_pkg::OFF_DATA, {24'h0, d});
      apb(1'b1, ulm_pkg::OFF_DATA, {24'h0, d2});
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h00);
      wait_ls(8'h40);
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h61);
      rd_chk(ulm_pkg::OFF_DATA, {24'h0, d});
      rd_chk(ulm_pkg::OFF_DATA, {24'h0, d2});
      rd_chk(ulm_pkg::OFF_LINE_STATUS, 32'h60);
      finish_test;
   end
endmodule
